/* File: logic/ucfg_device.sv */
/*
  Configuration register bank of the USB peripheral: hardware configuration,
  interrupt enable and DMA configuration words, interrupt pin and DMA control.
  Assumes the link and all event inputs are synchronous to REF_CLK.
*/
`timescale 1ns/1ps
`include "ucfg_map.svh"

module ucfg_device (
  input  wire logic                  REF_CLK,
  input  wire logic                  RST_N,
  ucfg_if.dev                        LINK,
  input  wire ucfg_pkg::ucfg_ep_vec_t EP_EVENT,
  input  wire logic                  PSEUDO_FRAME,
  input  wire logic                  FRAME_START,
  input  wire logic                  SUSPEND_STATE,
  input  wire logic                  RESUME_EVENT,
  input  wire logic                  BUS_RESET,
  input  wire logic                  IRQ_ACK,
  input  wire ucfg_pkg::ucfg_half_t  DMA_COUNT_LOAD,
  input  wire logic                  DMA_BYTE_DONE,
  input  wire logic                  SHORT_PACKET,
  input  wire logic                  EP_IS_OUT,
  output logic                       DMA_ACTIVE,
  output logic [3:0]                 DMA_ENDPOINT,
  output logic [4:0]                 DMA_BURST_BYTES,
  output logic [15:0]                DMA_COUNT,
  output logic                       TRANSFER_END
);
  import ucfg_pkg::*;

  localparam logic [1:0] PULSE_CYC = 2'(`UCFG_IRQ_PULSE_CYC);

  logic [15:0] hw_cfg;
  logic [31:0] int_en;
  logic [15:0] dma_cfg;
  logic [7:0]  cur_cmd;
  logic [2:0]  byte_idx;
  logic [31:0] stage;
  logic [31:0] next_stage;
  logic [2:0]  cur_len;
  logic        last_byte;
  logic        commit_hw;
  logic        commit_ie;
  logic        commit_dma;
  logic        dma_on;
  logic        dma_start;
  logic        dma_stop;
  logic        count_end;
  logic        short_end;
  logic        eot_event;
  logic        susp_q;
  logic [23:0] events;
  logic        irq_hit;
  logic        pending;
  logic [1:0]  pulse_cnt;
  logic        next_active;
  logic [31:0] rd_word;

  // Word selected by a read command, zero for anything else.
  function automatic logic [31:0] read_word(input logic [7:0] code,
                                            input logic [15:0] hw,
                                            input logic [31:0] ie,
                                            input logic [15:0] dma);
    case (code)
      `UCFG_CMD_HW_RD:  read_word = {16'h0000, hw};
      `UCFG_CMD_IE_RD:  read_word = ie;
      `UCFG_CMD_DMA_RD: read_word = {16'h0000, dma};
      default:          read_word = 32'h0000_0000;
    endcase
  endfunction : read_word

  assign cur_len   = ucfg_cmd_len(cur_cmd);
  assign last_byte = LINK.wr_strobe && (cur_len != 3'd0) && (byte_idx == cur_len - 3'd1);

  // Data bytes arrive least significant first.
  always_comb begin
    next_stage = stage;
    next_stage[{byte_idx[1:0], 3'b000} +: 8] = LINK.host_data;
  end

  assign commit_hw  = last_byte && (cur_cmd == `UCFG_CMD_HW_WR);
  assign commit_ie  = last_byte && (cur_cmd == `UCFG_CMD_IE_WR);
  assign commit_dma = last_byte && (cur_cmd == `UCFG_CMD_DMA_WR);

  // Command and byte sequencing on the link.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      cur_cmd  <= 8'h00;
      byte_idx <= 3'd0;
      stage    <= 32'h0000_0000;
    end else if (LINK.cmd_strobe) begin
      cur_cmd  <= LINK.host_data;
      byte_idx <= 3'd0;
      stage    <= 32'h0000_0000;
    end else if ((LINK.wr_strobe || LINK.rd_strobe) && (byte_idx < cur_len)) begin
      byte_idx <= byte_idx + 3'd1;
      if (LINK.wr_strobe) begin
        stage <= next_stage;
      end
    end
  end

  assign rd_word = read_word(cur_cmd, hw_cfg, int_en, dma_cfg);

  // Read bytes are answered on the cycle after the request.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      LINK.dev_data  <= 8'h00;
      LINK.dev_valid <= 1'b0;
    end else begin
      LINK.dev_valid <= LINK.rd_strobe;
      if (LINK.rd_strobe) begin
        LINK.dev_data <= rd_word[{byte_idx[1:0], 3'b000} +: 8];
      end
    end
  end

  // Hardware configuration keeps its value through a bus reset.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      hw_cfg <= `UCFG_HW_RST;
    end else if (commit_hw) begin
      hw_cfg <= next_stage[15:0];
    end
  end

  // Interrupt enable word is untouched by a bus reset.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      int_en <= `UCFG_IE_RST;
    end else if (commit_ie) begin
      int_en <= next_stage;
    end
  end

  assign dma_on    = dma_cfg[`UCFG_DMA_ENABLE];
  assign dma_start = commit_dma && next_stage[`UCFG_DMA_ENABLE] && !dma_on;
  assign dma_stop  = commit_dma && !next_stage[`UCFG_DMA_ENABLE] && dma_on;
  assign count_end = dma_on && dma_cfg[`UCFG_DMA_CNT_END] && DMA_BYTE_DONE
                     && (DMA_COUNT == 16'h0001);
  assign short_end = dma_on && dma_cfg[`UCFG_DMA_SHORT] && SHORT_PACKET
                     && EP_IS_OUT;
  assign eot_event = dma_stop || count_end || short_end;

  // DMA configuration; bus reset clears only the enable bit.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      dma_cfg <= `UCFG_DMA_RST;
    end else begin
      if (commit_dma) begin
        dma_cfg <= next_stage[15:0];
      end
      if (BUS_RESET || count_end || short_end) begin
        dma_cfg[`UCFG_DMA_ENABLE] <= 1'b0;
      end
    end
  end

  // Internal byte counter reloaded on each enable.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      DMA_COUNT <= 16'h0000;
    end else if (dma_start) begin
      DMA_COUNT <= DMA_COUNT_LOAD;
    end else if (dma_on && DMA_BYTE_DONE && (DMA_COUNT != 16'h0000)) begin
      DMA_COUNT <= DMA_COUNT - 16'h0001;
    end
  end

  // DMA control outputs.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      DMA_ACTIVE      <= 1'b0;
      DMA_ENDPOINT    <= 4'h0;
      DMA_BURST_BYTES <= 5'h01;
      TRANSFER_END    <= 1'b0;
    end else begin
      DMA_ACTIVE   <= dma_on;
      DMA_ENDPOINT <= dma_cfg[`UCFG_DMA_EP_LO +: 4];
      case (dma_cfg[`UCFG_DMA_BURST_LO +: 2])
        2'b00:   DMA_BURST_BYTES <= 5'h01;
        2'b01:   DMA_BURST_BYTES <= 5'h04;
        2'b10:   DMA_BURST_BYTES <= 5'h08;
        default: DMA_BURST_BYTES <= 5'h10;
      endcase
      TRANSFER_END <= eot_event;
    end
  end

  // Edge detector for entry into suspend.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      susp_q <= 1'b0;
    end else begin
      susp_q <= SUSPEND_STATE;
    end
  end

  // Event vector lines up with the enable word bits 23 to 0.
  assign events = {EP_EVENT,
                   2'b00,
                   PSEUDO_FRAME,
                   FRAME_START,
                   eot_event,
                   SUSPEND_STATE && !susp_q,
                   RESUME_EVENT,
                   BUS_RESET};
  assign irq_hit = |(events & int_en[23:0]);

  // Level mode request; a new event wins over an acknowledge.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pending <= 1'b0;
    end else if (irq_hit) begin
      pending <= 1'b1;
    end else if (IRQ_ACK) begin
      pending <= 1'b0;
    end
  end

  // Pulse mode timer, one pulse per event seen while the timer is idle; events during a pulse are dropped.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      pulse_cnt <= 2'd0;
    end else if (irq_hit && (pulse_cnt == 2'd0)) begin
      pulse_cnt <= PULSE_CYC;
    end else if (pulse_cnt != 2'd0) begin
      pulse_cnt <= pulse_cnt - 2'd1;
    end
  end

  always_comb begin
    if (hw_cfg[`UCFG_HW_SIG_MODE]) begin
      next_active = (pulse_cnt > 2'd1) || (irq_hit && (pulse_cnt == 2'd0));
    end else begin
      next_active = pending || irq_hit;
    end
  end

  // Interrupt and suspend pins.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      LINK.irq_pin     <= 1'b1;
      LINK.suspend_pin <= 1'b0;
    end else begin
      LINK.irq_pin     <= hw_cfg[`UCFG_HW_POLARITY] ? next_active : !next_active;
      LINK.suspend_pin <= hw_cfg[`UCFG_HW_POWER_OFF] && SUSPEND_STATE;
    end
  end

endmodule : ucfg_device

/* File: logic/ucfg_map.svh */
/*
  Command codes, byte counts, bit positions, reset values and timing counts of the
  configuration register bank. Assumes a single 10 MHz device clock.
*/
`ifndef UCFG_MAP_SVH
`define UCFG_MAP_SVH

// Link command codes.
`define UCFG_CMD_HW_WR      8'hba
`define UCFG_CMD_HW_RD      8'hbb
`define UCFG_CMD_IE_WR      8'hc2
`define UCFG_CMD_IE_RD      8'hc3
`define UCFG_CMD_DMA_WR     8'hf0
`define UCFG_CMD_DMA_RD     8'hf1

// Data bytes per transaction.
`define UCFG_LEN_IE         3'd4
`define UCFG_LEN_HALF       3'd2
`define UCFG_LEN_NONE       3'd0

// Reset values.
`define UCFG_HW_RST         16'h2340
`define UCFG_IE_RST         32'h0000_0000
`define UCFG_DMA_RST        16'h0000

// Hardware configuration bits.
`define UCFG_HW_POWER_OFF   2
`define UCFG_HW_SIG_MODE    1
`define UCFG_HW_POLARITY    0

// Interrupt enable bits.
`define UCFG_IE_EP_LO       8
`define UCFG_IE_EP_HI       23
`define UCFG_IE_RSV_MASK    32'h00ff_ffff

// DMA configuration bits.
`define UCFG_DMA_CNT_END    15
`define UCFG_DMA_SHORT      14
`define UCFG_DMA_EP_LO      4
`define UCFG_DMA_ENABLE     3
`define UCFG_DMA_BURST_LO   0

// Timing.
`define UCFG_CLK_MHZ        10
`define UCFG_IRQ_PULSE_NS   166
`define UCFG_IRQ_PULSE_CYC  ((`UCFG_IRQ_PULSE_NS * `UCFG_CLK_MHZ + 999) / 1000)

// Controller APB register offsets.
`define UCFG_APB_CMD        12'h000
`define UCFG_APB_WDATA      12'h004
`define UCFG_APB_RDATA      12'h008
`define UCFG_APB_STATUS     12'h00c

`endif

/* File: logic/ucfg_pkg.sv */
/*
  Types and the shared command decoder of the configuration register bank.
  Assumes ucfg_map.svh is on the include path.
*/
`include "ucfg_map.svh"

package ucfg_pkg;

  typedef logic [7:0]  ucfg_byte_t;
  typedef logic [15:0] ucfg_ep_vec_t;
  typedef logic [15:0] ucfg_half_t;

  typedef enum logic [2:0] {
    UCFG_IDLE    = 3'b000,
    UCFG_WRITE   = 3'b001,
    UCFG_RD_REQ  = 3'b010,
    UCFG_RD_WAIT = 3'b011
  } ucfg_state_t;

  // Number of data bytes that follow a command code.
  function automatic logic [2:0] ucfg_cmd_len(input logic [7:0] code);
    case (code)
      `UCFG_CMD_IE_WR, `UCFG_CMD_IE_RD: ucfg_cmd_len = `UCFG_LEN_IE;
      `UCFG_CMD_HW_WR, `UCFG_CMD_HW_RD,
      `UCFG_CMD_DMA_WR, `UCFG_CMD_DMA_RD: ucfg_cmd_len = `UCFG_LEN_HALF;
      default: ucfg_cmd_len = `UCFG_LEN_NONE;
    endcase
  endfunction : ucfg_cmd_len

endpackage : ucfg_pkg

/* File: logic/ucfg_if.sv */
/*
  Byte-wide command link between the controller and the configuration bank.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface ucfg_if;
  logic       cmd_strobe;
  logic       wr_strobe;
  logic       rd_strobe;
  logic [7:0] host_data;
  logic [7:0] dev_data;
  logic       dev_valid;
  logic       irq_pin;
  logic       suspend_pin;

  modport dev (
    input  cmd_strobe, wr_strobe, rd_strobe, host_data,
    output dev_data, dev_valid, irq_pin, suspend_pin
  );

  modport ctl (
    output cmd_strobe, wr_strobe, rd_strobe, host_data,
    input  dev_data, dev_valid, irq_pin, suspend_pin
  );
endinterface : ucfg_if

/* File: logic/ucfg_host.sv */
/*
  Controller end: takes commands from software over APB and runs byte
  transactions on the configuration link. Assumes one clock shared with the device.
*/
`timescale 1ns/1ps
`include "ucfg_map.svh"

module ucfg_host (
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  ucfg_if.ctl              LINK,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);
  import ucfg_pkg::*;

  ucfg_state_t state;
  logic [7:0]  code;
  logic [2:0]  len;
  logic [2:0]  idx;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        setup;
  logic        mapped;
  logic        start;

  assign setup  = PSEL && !PENABLE;
  assign mapped = (PADDR == `UCFG_APB_CMD) || (PADDR == `UCFG_APB_WDATA)
                  || (PADDR == `UCFG_APB_RDATA) || (PADDR == `UCFG_APB_STATUS);
  assign start  = PSEL && PENABLE && PREADY && PWRITE && (PADDR == `UCFG_APB_CMD)
                  && (state == UCFG_IDLE);

  // APB answer: one wait-free access phase, error on unmapped offsets.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && !mapped;
      if (setup && !PWRITE) begin
        case (PADDR)
          `UCFG_APB_CMD:    PRDATA <= {24'h000000, code};
          `UCFG_APB_WDATA:  PRDATA <= wdata;
          `UCFG_APB_RDATA:  PRDATA <= rdata;
          `UCFG_APB_STATUS: PRDATA <= {29'h0, LINK.suspend_pin, LINK.irq_pin,
                                       state != UCFG_IDLE};
          default:          PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Write data register; reserved enable bits are forced to zero.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      wdata <= 32'h0000_0000;
    end else if (PSEL && PENABLE && PREADY && PWRITE && (PADDR == `UCFG_APB_WDATA)) begin
      wdata <= PWDATA;
    end else if (start && (PWDATA[7:0] == `UCFG_CMD_IE_WR)) begin
      wdata <= wdata & `UCFG_IE_RSV_MASK;
    end
  end

  // Link sequencer: command byte, then data bytes least significant first.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state           <= UCFG_IDLE;
      code            <= 8'h00;
      len             <= 3'd0;
      idx             <= 3'd0;
      rdata           <= 32'h0000_0000;
      LINK.cmd_strobe <= 1'b0;
      LINK.wr_strobe  <= 1'b0;
      LINK.rd_strobe  <= 1'b0;
      LINK.host_data  <= 8'h00;
    end else begin
      LINK.cmd_strobe <= 1'b0;
      LINK.wr_strobe  <= 1'b0;
      LINK.rd_strobe  <= 1'b0;
      case (state)
        UCFG_IDLE: begin
          if (start) begin
            code            <= PWDATA[7:0];
            len             <= ucfg_cmd_len(PWDATA[7:0]);
            idx             <= 3'd0;
            LINK.cmd_strobe <= 1'b1;
            LINK.host_data  <= PWDATA[7:0];
            if (ucfg_cmd_len(PWDATA[7:0]) == 3'd0) begin
              state <= UCFG_IDLE;
            end else if (PWDATA[0]) begin
              rdata <= 32'h0000_0000;
              state <= UCFG_RD_REQ;
            end else begin
              state <= UCFG_WRITE;
            end
          end
        end
        UCFG_WRITE: begin
          LINK.wr_strobe <= 1'b1;
          LINK.host_data <= wdata[{idx[1:0], 3'b000} +: 8];
          idx            <= idx + 3'd1;
          if (idx == len - 3'd1) begin
            state <= UCFG_IDLE;
          end
        end
        UCFG_RD_REQ: begin
          LINK.rd_strobe <= 1'b1;
          state          <= UCFG_RD_WAIT;
        end
        UCFG_RD_WAIT: begin
          if (LINK.dev_valid) begin
            rdata[{idx[1:0], 3'b000} +: 8] <= LINK.dev_data;
            idx                            <= idx + 3'd1;
            state <= (idx == len - 3'd1) ? UCFG_IDLE : UCFG_RD_REQ;
          end
        end
        default: begin
          state <= UCFG_IDLE;
        end
      endcase
    end
  end

endmodule : ucfg_host

/* File: verification/ucfg_link_asserts.sv */
/*
  Checker of the configuration link: byte counts, read answers, interrupt pin.
  Assumes it is instantiated beside the link interface, on the one device clock.
*/
`timescale 1ns/1ps
`include "ucfg_map.svh"

module ucfg_link_asserts (
  input wire logic       REF_CLK,
  input wire logic       RST_N,
  input wire logic       cmd_strobe,
  input wire logic       wr_strobe,
  input wire logic       rd_strobe,
  input wire logic [7:0] host_data,
  input wire logic [7:0] dev_data,
  input wire logic       dev_valid,
  input wire logic       irq_pin,
  input wire logic       suspend_pin
);
  logic [7:0] code;
  logic [7:0] lo_byte;
  logic [7:0] hw_lo;
  logic       hw_idx;
  logic       act;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  assign act = (irq_pin == hw_lo[`UCFG_HW_POLARITY]);

  // Shadow of the low hardware configuration byte, taken from link writes.
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      code    <= 8'h00;
      lo_byte <= 8'h00;
      hw_lo   <= 8'h40;
      hw_idx  <= 1'b0;
    end else if (cmd_strobe) begin
      code   <= host_data;
      hw_idx <= 1'b0;
    end else if (wr_strobe && code == `UCFG_CMD_HW_WR) begin
      hw_idx <= 1'b1;
      if (!hw_idx) begin
        lo_byte <= host_data;
      end else begin
        hw_lo <= lo_byte;
      end
    end
  end

  rd_answer_a: assert property (rd_strobe |=> dev_valid)
    else $error("read byte not answered in the next cycle");
  valid_cause_a: assert property (dev_valid |-> $past(rd_strobe))
    else $error("read byte given without a request");
  ie_write_len_a: assert property (
    cmd_strobe && host_data == `UCFG_CMD_IE_WR |=> wr_strobe [*4] ##1 !wr_strobe)
    else $error("enable word write is not four bytes");
  ie_read_len_a: assert property (
    cmd_strobe && host_data == `UCFG_CMD_IE_RD |=>
      rd_strobe ##3 rd_strobe ##3 rd_strobe ##3 rd_strobe ##3 !rd_strobe)
    else $error("enable word read is not four bytes");
  dma_write_len_a: assert property (
    cmd_strobe && host_data == `UCFG_CMD_DMA_WR |=> wr_strobe [*2] ##1 !wr_strobe)
    else $error("DMA word write is not two bytes");
  dma_read_len_a: assert property (
    cmd_strobe && host_data == `UCFG_CMD_DMA_RD |=> rd_strobe ##3 rd_strobe ##3 !rd_strobe)
    else $error("DMA word read is not two bytes");
  reset_idle_a: assert property ($rose(RST_N) |-> irq_pin && !suspend_pin)
    else $error("pins not idle after reset");
  irq_pulse_a: assert property (
    hw_lo[`UCFG_HW_SIG_MODE] && $past(hw_lo, 4) == hw_lo && $rose(act) |=> act ##1 !act)
    else $error("interrupt pulse is not two cycles");
endmodule : ucfg_link_asserts

/* File: verification/usb_device_irq_dma_config_regs_test.sv */
/*
  Testbench: both ends joined by the link, driven over APB and event inputs.
  Assumes the design files and ucfg_map.svh are compiled first.
*/
`timescale 1ns/1ps
`include "ucfg_map.svh"

module usb_device_irq_dma_config_regs_test;
  import ucfg_pkg::*;
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end

  logic          REF_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
  logic [11:0]   PADDR;
  logic [31:0]   PWDATA, PRDATA, q;
  ucfg_ep_vec_t  EP_EVENT;
  ucfg_half_t    DMA_COUNT_LOAD;
  logic          PSEUDO_FRAME, FRAME_START, SUSPEND_STATE, RESUME_EVENT, BUS_RESET;
  logic          IRQ_ACK, DMA_BYTE_DONE, SHORT_PACKET, EP_IS_OUT, DMA_ACTIVE, TRANSFER_END;
  logic [3:0]    DMA_ENDPOINT;
  logic [4:0]    DMA_BURST_BYTES;
  logic [15:0]   DMA_COUNT;
  int            bad_count = 0, total_checks = 0, cyc = 0, te_seen = 0, hi_cyc = 0, t0;
  int            ev [9] = '{0, 1, 2, 4, 5, 8, 9, 10, 23};
  logic [4:0]    bl [4] = '{5'd1, 5'd4, 5'd8, 5'd16};

  ucfg_if ucfg_if_inst ();
  ucfg_device ucfg_device_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .LINK(ucfg_if_inst),
    .EP_EVENT(EP_EVENT), .PSEUDO_FRAME(PSEUDO_FRAME), .FRAME_START(FRAME_START),
    .SUSPEND_STATE(SUSPEND_STATE), .RESUME_EVENT(RESUME_EVENT), .BUS_RESET(BUS_RESET),
    .IRQ_ACK(IRQ_ACK), .DMA_COUNT_LOAD(DMA_COUNT_LOAD), .DMA_BYTE_DONE(DMA_BYTE_DONE),
    .SHORT_PACKET(SHORT_PACKET), .EP_IS_OUT(EP_IS_OUT), .DMA_ACTIVE(DMA_ACTIVE),
    .DMA_ENDPOINT(DMA_ENDPOINT), .DMA_BURST_BYTES(DMA_BURST_BYTES),
    .DMA_COUNT(DMA_COUNT), .TRANSFER_END(TRANSFER_END));
  ucfg_host ucfg_host_inst (.REF_CLK(REF_CLK), .RST_N(RST_N), .LINK(ucfg_if_inst),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
  ucfg_link_asserts ucfg_link_asserts_inst (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .cmd_strobe(ucfg_if_inst.cmd_strobe), .wr_strobe(ucfg_if_inst.wr_strobe),
    .rd_strobe(ucfg_if_inst.rd_strobe), .host_data(ucfg_if_inst.host_data),
    .dev_data(ucfg_if_inst.dev_data), .dev_valid(ucfg_if_inst.dev_valid),
    .irq_pin(ucfg_if_inst.irq_pin), .suspend_pin(ucfg_if_inst.suspend_pin));

  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // Counts end-of-transfer pulses and active-high interrupt cycles; cuts a hang.
  always @(posedge REF_CLK) begin
    cyc++;
    if (TRANSFER_END === 1'b1) te_seen++;
    if (ucfg_if_inst.irq_pin === 1'b1) hi_cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  // Runs one link command and leaves its read result in q.
  task automatic cmd(input logic [7:0] c, input logic [31:0] d);
    apb(1'b1, `UCFG_APB_WDATA, d);
    apb(1'b1, `UCFG_APB_CMD, {24'h000000, c});
    do begin
      apb(1'b0, `UCFG_APB_STATUS, 32'h0);
    end while (q[0] !== 1'b0);
    apb(1'b0, `UCFG_APB_RDATA, 32'h0);
  endtask : cmd

  task automatic fire(input int i);
    @(posedge REF_CLK);
    case (i)
      0: BUS_RESET <= 1'b1;
      1: RESUME_EVENT <= 1'b1;
      2: SUSPEND_STATE <= 1'b1;
      4: FRAME_START <= 1'b1;
      5: PSEUDO_FRAME <= 1'b1;
      default: EP_EVENT[i-8] <= 1'b1;
    endcase
    @(posedge REF_CLK);
    {BUS_RESET, RESUME_EVENT, SUSPEND_STATE, FRAME_START, PSEUDO_FRAME} <= 5'h00;
    EP_EVENT <= 16'h0000;
    @(posedge REF_CLK);
  endtask : fire

  task automatic ack(input logic idle);
    @(posedge REF_CLK);
    IRQ_ACK <= 1'b1;
    @(posedge REF_CLK);
    IRQ_ACK <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    `CHK("irq released", idle, ucfg_if_inst.irq_pin)
  endtask : ack

  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, EP_EVENT} = '0;
    {PSEUDO_FRAME, FRAME_START, SUSPEND_STATE, RESUME_EVENT, BUS_RESET} = '0;
    {IRQ_ACK, DMA_BYTE_DONE, SHORT_PACKET, EP_IS_OUT} = '0;
    DMA_COUNT_LOAD = 16'h0003;
    RST_N = 1'b0;
    repeat (5) @(posedge REF_CLK);
    RST_N <= 1'b1;
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    cmd(`UCFG_CMD_HW_RD, 32'h0);
    `CHK("hw word reset", 32'h0000_2340, q)
    cmd(`UCFG_CMD_IE_RD, 32'h0);
    `CHK("ie word reset", 32'h0000_0000, q)
    cmd(`UCFG_CMD_DMA_RD, 32'h0);
    `CHK("dma word reset", 32'h0000_0000, q)
    foreach (ev[k]) fire(ev[k]);
    `CHK("irq with all disabled", 1'b1, ucfg_if_inst.irq_pin)
    SUSPEND_STATE <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    `CHK("suspend pin off", 1'b0, ucfg_if_inst.suspend_pin)
    cmd(`UCFG_CMD_HW_WR, 32'h0000_2344);
    `CHK("suspend pin on", 1'b1, ucfg_if_inst.suspend_pin)
    SUSPEND_STATE <= 1'b0;
    foreach (ev[k]) begin
      cmd(`UCFG_CMD_IE_WR, 32'h1 << ev[k]);
      fire(ev[k]);
      `CHK("irq on enabled event", 1'b0, ucfg_if_inst.irq_pin)
      ack(1'b1);
    end
    cmd(`UCFG_CMD_IE_WR, 32'ha5ff_ffff);
    cmd(`UCFG_CMD_IE_RD, 32'h0);
    `CHK("ie word readback", 32'h00ff_ffff, q)
    fire(0);
    ack(1'b1);
    cmd(`UCFG_CMD_IE_RD, 32'h0);
    `CHK("ie word after bus reset", 32'h00ff_ffff, q)
    cmd(`UCFG_CMD_IE_WR, 32'h0000_0008);
    for (int b = 0; b < 4; b++) begin
      cmd(`UCFG_CMD_DMA_WR, {24'h000000, 8'h58 | b[7:0]});
      `CHK("burst bytes", bl[b], DMA_BURST_BYTES)
      `CHK("dma endpoint", 4'h5, DMA_ENDPOINT)
      `CHK("dma active", 1'b1, DMA_ACTIVE)
    end
    `CHK("count reloaded", 16'h0003, DMA_COUNT)
    cmd(`UCFG_CMD_DMA_RD, 32'h0);
    `CHK("dma word readback", 32'h0000_005b, q)
    fire(0);
    ack(1'b1);
    cmd(`UCFG_CMD_DMA_RD, 32'h0);
    `CHK("dma word after bus reset", 32'h0000_0053, q)
    cmd(`UCFG_CMD_DMA_WR, 32'h0000_8058);
    `CHK("count reloaded again", 16'h0003, DMA_COUNT)
    t0 = te_seen;
    repeat (3) begin
      @(posedge REF_CLK);
      DMA_BYTE_DONE <= 1'b1;
      @(posedge REF_CLK);
      DMA_BYTE_DONE <= 1'b0;
    end
    repeat (3) @(posedge REF_CLK);
    `CHK("counter end", 1, te_seen - t0)
    `CHK("transfer end irq", 1'b0, ucfg_if_inst.irq_pin)
    ack(1'b1);
    EP_IS_OUT <= 1'b1;
    cmd(`UCFG_CMD_DMA_WR, 32'h0000_4058);
    `CHK("count reloaded from zero", 16'h0003, DMA_COUNT)
    t0 = te_seen;
    @(posedge REF_CLK);
    SHORT_PACKET <= 1'b1;
    @(posedge REF_CLK);
    SHORT_PACKET <= 1'b0;
    repeat (3) @(posedge REF_CLK);
    `CHK("short packet end", 1, te_seen - t0)
    `CHK("short packet stops", 1'b0, DMA_ACTIVE)
    ack(1'b1);
    cmd(`UCFG_CMD_DMA_WR, 32'h0000_0058);
    t0 = te_seen;
    cmd(`UCFG_CMD_DMA_WR, 32'h0000_0050);
    `CHK("disable ends transfer", 1, te_seen - t0)
    `CHK("disable stops", 1'b0, DMA_ACTIVE)
    ack(1'b1);
    cmd(`UCFG_CMD_HW_WR, 32'h0000_2347);
    `CHK("active high idle", 1'b0, ucfg_if_inst.irq_pin)
    cmd(`UCFG_CMD_IE_WR, 32'h0000_0010);
    t0 = hi_cyc;
    fire(4);
    repeat (6) @(posedge REF_CLK);
    `CHK("pulse cycles", 2, hi_cyc - t0)
    cmd(`UCFG_CMD_HW_WR, 32'h0000_2345);
    fire(4);
    `CHK("active high level", 1'b1, ucfg_if_inst.irq_pin)
    ack(1'b0);
    final_report();
  end
endmodule : usb_device_irq_dma_config_regs_test
